// ### hdl/sentrx_pkg.sv
package sentrx_pkg;

  // ************************************************************
  // widths
  // ************************************************************
  localparam int MSG_W = 28;           // status nibble + 6 data nibbles
  localparam int FIFO_DEPTH = 8;       // buffered messages
  localparam int TICK_W = 10;          // pulse length in ticks
  localparam int DIV_W = 8;            // clocks per tick counter

  // ************************************************************
  // pulse windows, in ticks
  // ************************************************************
  localparam logic [9:0] NIB_MIN = 10'h00C;    // nibble 0
  localparam logic [9:0] NIB_MAX = 10'h01B;    // nibble 15
  localparam logic [9:0] CAL_MIN = 10'h02A;    // 56 ticks -25%
  localparam logic [9:0] CAL_MAX = 10'h046;    // 56 ticks +25%
  localparam logic [9:0] PAUSE_MIN = 10'h01C;  // above nibble range
  localparam logic [9:0] PAUSE_MAX = 10'h300;  // 768 ticks
  localparam logic [9:0] TICK_SAT = 10'h3FF;   // period saturates

  // ************************************************************
  // crc and reset values
  // ************************************************************
  localparam logic [3:0] CRC_SEED = 4'h5;
  localparam logic [3:0] CRC_POLY = 4'hD;      // x^4+x^3+x^2+1
  localparam logic [5:0] STATUS_RST = 6'h00;
  localparam logic [3:0] EDGE_BASE = 4'h2;     // status + crc pulses

  // ************************************************************
  // channel_status bit positions
  // ************************************************************
  localparam int ST_NIB = 0;    // nibble_value_error
  localparam int ST_CRC = 1;    // fast_msg_crc_error
  localparam int ST_CAL = 2;    // cal_length_error
  localparam int ST_OFL = 3;    // fast_msg_overflow
  localparam int ST_PP = 4;     // pause_diag_error
  localparam int ST_EDGE = 5;   // edge count error

  // ************************************************************
  // decoder states
  // ************************************************************
  typedef enum logic [2:0] {
    S_WAIT_CAL = 3'b000,  // hunting for a calibration pulse
    S_STATUS = 3'b001,    // status nibble
    S_DATA = 3'b010,      // data nibbles
    S_CRC = 3'b011,       // crc nibble
    S_PAUSE = 3'b100,     // pause pulse expected
    S_CAL = 3'b101,       // next calibration expected
    S_EXTRA = 3'b110      // surplus nibbles before a late pause
  } sentrx_state_t;

endpackage

// ### hdl/sentrx_stream_if.sv
`timescale 1ns/1ns
// message stream between decoder and buffer
interface sentrx_stream_if;
  logic [sentrx_pkg::MSG_W-1:0] data;  // status and data nibbles
  logic valid;                         // data offered
  logic ready;                         // data accepted
  modport src(output data, output valid, input ready);
  modport snk(input data, input valid, output ready);
endinterface

// ### hdl/sentrx_fifo.sv
`timescale 1ns/1ns
// shifting fifo: head always sits in entry 0, so its data is a flop
module sentrx_fifo #(
  parameter int WIDTH = sentrx_pkg::MSG_W,
  parameter int DEPTH = sentrx_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // filling side
  sentrx_stream_if.snk wr,
  // draining side
  sentrx_stream_if.src rd
);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];  // entries, 0 is the head
  logic [CW-1:0] count;           // entries in use
  logic [CW-1:0] next_count;
  logic valid_q;                  // registered not empty
  logic ready_q;                  // registered not full
  wire push = wr.valid & ready_q;
  wire pop = valid_q & rd.ready;

  // ************************************************************
  // occupancy
  // ************************************************************
  assign next_count = count + CW'(push) - CW'(pop);
  assign rd.data = mem[0];
  assign rd.valid = valid_q;
  assign wr.ready = ready_q;

  // flags follow the next count so they never lag a cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= '0;
      valid_q <= 1'b0;
      ready_q <= 1'b1;
    end else begin
      count <= next_count;
      valid_q <= next_count != '0;
      ready_q <= next_count != CW'(DEPTH);
    end
  end

  // ************************************************************
  // entries
  // ************************************************************
  genvar i;
  generate
    for (i = 0; i < DEPTH; i++) begin : g_ent
      wire [WIDTH-1:0] upper;     // neighbour moving down on pop
      wire [WIDTH-1:0] next_ent;
      wire load_pop = pop & push & (count == CW'(i + 1));
      wire load_hold = ~pop & push & (count == CW'(i));
      if (i == DEPTH - 1) begin : g_top
        assign upper = '0;
      end else begin : g_mid
        assign upper = mem[i+1];
      end
      assign next_ent = (load_pop | load_hold) ? wr.data :
                        pop ? upper : mem[i];
      // one entry, shifted or loaded
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          mem[i] <= '0;
        end else begin
          mem[i] <= next_ent;
        end
      end
    end
  endgenerate

endmodule

// ### hdl/sentrx_channel.sv
`timescale 1ns/1ns
// Functional notes
// - pause enabled means pause follows the crc nibble
// - pause mode lets other errors raise edge error
// - nibble error sends decoder to wait calibration
// - pause then calibration give second edge error
// - crc error behaves like nibble error
// - bad calibration length yields one edge error, two in pause mode
// - overflow may force wait, one edge error in pause mode, none without pause
// - too few edges: pause read as nibble
// - late pause decoded as nibble, nibble error
// - too many edges also raise pause diagnostic
// - follow-on flag may land in next frame
// - clean messages never raise edge error unless an overflow forces wait
module sentrx_channel (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // sensor pin
  input wire logic sent_in,
  // channel_config
  input wire logic rx_enable,
  input wire logic pause_en,
  input wire logic [2:0] data_nibbles,
  input wire logic [sentrx_pkg::DIV_W-1:0] tick_div,
  // channel_status
  input wire logic [5:0] status_clear,
  output logic [5:0] channel_status,
  // received messages
  output logic [sentrx_pkg::MSG_W-1:0] msg_data,
  output logic msg_valid,
  input wire logic msg_ready
);

  // ************************************************************
  // declarations
  // ************************************************************
  sentrx_stream_if wr_if ();   // decoder to buffer
  sentrx_stream_if rd_if ();   // buffer to user
  sentrx_pkg::sentrx_state_t state, next_state;
  logic sent_q;                // previous pin sample
  logic [sentrx_pkg::DIV_W-1:0] div_cnt;
  logic [9:0] per_cnt;         // ticks since last falling edge
  logic armed;                 // one falling edge seen
  logic synced;                // one marker seen, counting valid
  logic [3:0] ecnt;            // pulses since last marker
  logic [3:0] next_ecnt;
  logic [2:0] idx, next_idx;   // data nibble index
  logic [3:0] crc, next_crc;
  logic [3:0] stat, next_stat; // status nibble
  logic [23:0] shift, next_shift;
  logic [5:0] err_set;
  logic push, force_wait;
  logic chance;                // free toggle, decorrelates overflow

  // ************************************************************
  // tick divider and pulse measurement
  // ************************************************************
  wire tick = div_cnt == '0;
  wire fall = sent_q & ~sent_in;
  wire pulse_ev = fall & armed & rx_enable;
  wire [9:0] plen = per_cnt;
  wire [3:0] nib = 4'(plen - sentrx_pkg::NIB_MIN);
  wire is_nib = plen >= sentrx_pkg::NIB_MIN && plen <= sentrx_pkg::NIB_MAX;
  wire is_long = plen > sentrx_pkg::NIB_MAX;
  wire is_cal = plen >= sentrx_pkg::CAL_MIN && plen <= sentrx_pkg::CAL_MAX;
  wire is_pause = plen >= sentrx_pkg::PAUSE_MIN &&
                  plen <= sentrx_pkg::PAUSE_MAX;
  wire last_nib = idx == data_nibbles - 3'h1;

  // pin sample and tick prescaler
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sent_q <= 1'b1;
      div_cnt <= '0;
    end else begin
      sent_q <= sent_in;
      div_cnt <= tick ? tick_div - 8'h01 : div_cnt - 8'h01;
    end
  end

  // period counter restarts on each falling edge, saturates when idle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      per_cnt <= '0;
      armed <= 1'b0;
    end else if (!rx_enable) begin
      per_cnt <= '0;
      armed <= 1'b0;
    end else if (fall) begin
      // the tick at the edge itself counts, so L ticks read as L
      per_cnt <= {9'h000, tick};
      armed <= 1'b1;
    end else if (tick && per_cnt != sentrx_pkg::TICK_SAT) begin
      per_cnt <= per_cnt + 10'h001;
    end
  end

  // ************************************************************
  // edge counter
  // ************************************************************
  // expected pulses between calibrations: status, data, crc, pause
  wire [3:0] expected = sentrx_pkg::EDGE_BASE + {1'b0, data_nibbles} +
                        {3'h0, pause_en};
  // while hunting, pause mode takes any long pulse as a marker, so a
  // pause and the calibration after it look like two back to back
  // calibrations with nothing between them
  wire hunt_mark = state == sentrx_pkg::S_WAIT_CAL &&
                   (pause_en ? is_long : is_cal);
  wire good_mark = state == sentrx_pkg::S_CAL && is_cal;
  wire marker = pulse_ev & (hunt_mark | good_mark);
  wire edge_err = marker & synced & (ecnt != expected);
  // an overflow-forced wait credits the pause so only one error follows
  wire [3:0] credit = {3'h0, pause_en & force_wait};

  assign next_ecnt = marker ? 4'h0 :
                     pulse_ev ? 4'(ecnt + 4'h1 + credit) : ecnt;

  // bad calibration keeps counting, no end of message is marked
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ecnt <= '0;
      synced <= 1'b0;
    end else if (!rx_enable) begin
      ecnt <= '0;
      synced <= 1'b0;
    end else begin
      ecnt <= next_ecnt;
      synced <= synced | marker;
    end
  end

  // ************************************************************
  // crc step over one nibble, msb first
  // ************************************************************
  function automatic logic [3:0] sentrx_crc_step(input logic [3:0] c,
                                                 input logic [3:0] d);
    logic [3:0] r;
    logic fb;
    r = c;
    for (int b = 3; b >= 0; b--) begin
      fb = r[3] ^ d[b];
      r = {r[2:0], 1'b0} ^ (fb ? sentrx_pkg::CRC_POLY : 4'h0);
    end
    return r;
  endfunction

  // ************************************************************
  // decoder
  // ************************************************************
  // every branch is entered only on a measured pulse
  always_comb begin
    next_state = state;
    next_idx = idx;
    next_crc = crc;
    next_stat = stat;
    next_shift = shift;
    err_set = '0;
    push = 1'b0;
    force_wait = 1'b0;
    if (pulse_ev) begin
      unique case (state)
        sentrx_pkg::S_WAIT_CAL, sentrx_pkg::S_CAL: begin
          if (is_cal) begin
            next_state = sentrx_pkg::S_STATUS;
          end else begin
            // hunting in pause mode takes a long pulse as a marker,
            // not as a calibration of bad length
            if (state == sentrx_pkg::S_CAL || (is_long && !pause_en)) begin
              err_set[sentrx_pkg::ST_CAL] = 1'b1;
            end
            next_state = sentrx_pkg::S_WAIT_CAL;
          end
        end
        sentrx_pkg::S_STATUS: begin
          next_stat = nib;
          next_crc = sentrx_pkg::CRC_SEED;
          next_idx = 3'h0;
          next_shift = '0;
          if (!is_nib) begin
            err_set[sentrx_pkg::ST_NIB] = 1'b1;
            next_state = sentrx_pkg::S_WAIT_CAL;
          end else begin
            next_state = sentrx_pkg::S_DATA;
          end
        end
        sentrx_pkg::S_DATA: begin
          next_shift = {shift[19:0], nib};
          next_crc = sentrx_crc_step(crc, nib);
          next_idx = idx + 3'h1;
          // a pause arriving early lands here as a bad nibble
          if (!is_nib) begin
            err_set[sentrx_pkg::ST_NIB] = 1'b1;
            next_state = sentrx_pkg::S_WAIT_CAL;
          end else if (last_nib) begin
            next_state = sentrx_pkg::S_CRC;
          end
        end
        sentrx_pkg::S_CRC: begin
          if (!is_nib) begin
            err_set[sentrx_pkg::ST_NIB] = 1'b1;
            next_state = sentrx_pkg::S_WAIT_CAL;
          end else if (nib != crc) begin
            err_set[sentrx_pkg::ST_CRC] = 1'b1;
            next_state = sentrx_pkg::S_WAIT_CAL;
          end else begin
            push = 1'b1;
            next_state = pause_en ? sentrx_pkg::S_PAUSE :
                                    sentrx_pkg::S_CAL;
            if (!wr_if.ready) begin
              err_set[sentrx_pkg::ST_OFL] = 1'b1;
              // overflow sometimes upsets the decoder
              if (chance) begin
                force_wait = 1'b1;
                next_state = sentrx_pkg::S_WAIT_CAL;
              end
            end
          end
        end
        sentrx_pkg::S_PAUSE: begin
          if (is_pause) begin
            next_state = sentrx_pkg::S_CAL;
          end else begin
            // surplus edge: length is wrong; a nibble keeps decoding, anything else waits for calibration
            err_set[sentrx_pkg::ST_PP] = 1'b1;
            next_state = is_nib ? sentrx_pkg::S_EXTRA :
                                  sentrx_pkg::S_WAIT_CAL;
          end
        end
        sentrx_pkg::S_EXTRA: begin
          // the late pause is seen as a nibble out of range
          if (!is_nib) begin
            err_set[sentrx_pkg::ST_NIB] = 1'b1;
            next_state = sentrx_pkg::S_WAIT_CAL;
          end
        end
        default: begin
          next_state = sentrx_pkg::S_WAIT_CAL;
        end
      endcase
    end
    // edge error reported at the marker, often a frame later
    err_set[sentrx_pkg::ST_EDGE] = edge_err;
  end

  // decoder registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= sentrx_pkg::S_WAIT_CAL;
      idx <= '0;
      crc <= sentrx_pkg::CRC_SEED;
      stat <= '0;
      shift <= '0;
      chance <= 1'b0;
    end else begin
      state <= rx_enable ? next_state : sentrx_pkg::S_WAIT_CAL;
      idx <= next_idx;
      crc <= next_crc;
      stat <= next_stat;
      shift <= next_shift;
      chance <= ~chance;
    end
  end

  // ************************************************************
  // sticky status, set wins over clear
  // ************************************************************
  // flags are never cleared by hardware, so software cannot tell the
  // first error from the ones it drags along
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      channel_status <= sentrx_pkg::STATUS_RST;
    end else begin
      channel_status <= (channel_status & ~status_clear) | err_set;
    end
  end

  // ************************************************************
  // message buffer
  // ************************************************************
  // a full buffer drops the new message rather than stalling the pin
  assign wr_if.valid = push;
  assign wr_if.data = {stat, shift};
  assign rd_if.ready = msg_ready;
  assign msg_data = rd_if.data;
  assign msg_valid = rd_if.valid;

  sentrx_fifo #(
    .WIDTH(sentrx_pkg::MSG_W),
    .DEPTH(sentrx_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .wr(wr_if),
    .rd(rd_if)
  );

endmodule

// ### test/sentrx_channel_chk.sv
`timescale 1ns/1ns
// ************************************************************
// pin and flag checker
// ************************************************************
module sentrx_channel_chk (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // pin and config
  input wire logic sent_in,
  input wire logic rx_enable,
  input wire logic pause_en,
  // status
  input wire logic [5:0] status_clear,
  input wire logic [5:0] channel_status,
  // messages
  input wire logic [sentrx_pkg::MSG_W-1:0] msg_data,
  input wire logic msg_valid,
  input wire logic msg_ready
);
  localparam logic [5:0] OFL = 6'h08;   // overflow flag position
  localparam logic [5:0] EDGE = 6'h20;  // edge count flag position
  logic pin_q;             // last pin sample
  logic [3:0] fall_age;    // cycles since a falling edge, saturating
  logic [3:0] next_age;
  logic [5:0] status_q;    // flags one cycle ago
  logic [5:0] rise;        // flags rising now
  logic other_seen;        // a non-edge flag rose since reset
  assign rise = channel_status & ~status_q;
  assign next_age = (pin_q && !sent_in) ? 4'h0 :
                    (&fall_age) ? fall_age : fall_age + 4'h1;
  // helper state; the pin sample resets to the idle-high level
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_q <= 1'b1;
      fall_age <= 4'hF;
      status_q <= 6'h00;
      other_seen <= 1'b0;
    end else begin
      pin_q <= sent_in;
      fall_age <= next_age;
      status_q <= channel_status;
      other_seen <= other_seen | (|(rise & ~EDGE));
    end
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  property p_sticky;
    (status_q & ~$past(status_clear) & ~channel_status) == 6'h00;
  endproperty
  property p_clear;
    // flags are only set on a pin fall, so none may race this clear
    (|status_clear) && !(pin_q && !sent_in) |=>
      (channel_status & $past(status_clear)) == 6'h00;
  endproperty
  property p_flag_on_fall;
    |(rise & ~OFL) |-> fall_age <= 4'h2;
  endproperty
  property p_valid_rise;
    $rose(msg_valid) |-> fall_age <= 4'h4;
  endproperty
  property p_hold;
    msg_valid && !msg_ready |=> msg_valid && $stable(msg_data);
  endproperty
  property p_ovf;
    rise[sentrx_pkg::ST_OFL] |-> msg_valid;
  endproperty
  // weak by design: other_seen never clears, so only a first error
  // that is an edge error alone is caught
  property p_edge_cause;
    pause_en && rise[sentrx_pkg::ST_EDGE] |->
      other_seen || (|(rise & ~EDGE));
  endproperty
  property p_rx_off;
    !rx_enable && !$past(rx_enable) |-> rise == 6'h00 && !$rose(msg_valid);
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("flag dropped without a clear");
  a_clear: assert property (p_clear)
    else $error("flag survived its clear");
  a_flag_on_fall: assert property (p_flag_on_fall)
    else $error("flag rose away from a pin edge");
  a_valid_rise: assert property (p_valid_rise)
    else $error("message appeared away from a pin edge");
  a_hold: assert property (p_hold)
    else $error("queued message changed while stalled");
  a_ovf: assert property (p_ovf)
    else $error("overflow with an empty buffer");
  a_edge_cause: assert property (p_edge_cause)
    else $error("edge error with no earlier cause");
  a_rx_off: assert property (p_rx_off)
    else $error("activity while receive is off");
  cover property (rise[sentrx_pkg::ST_EDGE]);
  cover property (rise[sentrx_pkg::ST_OFL]);
  cover property (rise[sentrx_pkg::ST_PP]);
  cover property (msg_valid && msg_ready);
endmodule
bind sentrx_channel sentrx_channel_chk chk_u (
  .clk(clk), .reset_n(reset_n), .sent_in(sent_in),
  .rx_enable(rx_enable), .pause_en(pause_en),
  .status_clear(status_clear), .channel_status(channel_status),
  .msg_data(msg_data), .msg_valid(msg_valid), .msg_ready(msg_ready)
);

// ### test/sentrx_sensor.sv
`timescale 1ns/1ns
// ************************************************************
// sensor model, push-pull on the single pin
// ************************************************************
module sentrx_sensor (
  // clock
  input wire logic clk,
  // sensor pin
  output logic sent_in
);
  localparam int LOW_T = 5;  // low part of each pulse, in ticks
  // line idles high before the first frame
  initial begin
    sent_in = 1'b1;
  end
  // pulse of len ticks, fall to fall; a caller that waits stretches it
  task automatic pulse(input int len);
    @(negedge clk);
    sent_in = 1'b0;
    repeat (LOW_T) @(negedge clk);
    sent_in = 1'b1;
    repeat (len - LOW_T - 1) @(negedge clk);
  endtask
endmodule

// ### test/sentrx_channel_bench.sv
`timescale 1ns/1ns
// ************************************************************
// bench for the receive channel
// ************************************************************
module sentrx_channel_bench;
  logic clk, reset_n, sent_in, rx_enable, pause_en, msg_ready;
  logic [2:0] data_nibbles;
  logic [sentrx_pkg::DIV_W-1:0] tick_div;
  logic [5:0] status_clear, channel_status;
  logic [sentrx_pkg::MSG_W-1:0] msg_data;
  logic msg_valid;
  logic [sentrx_pkg::MSG_W-1:0] exp_q[$];  // messages still due
  int q[$];  // nibble values of the next frame
  int num_errors = 0;
  int comparisons = 0;
  localparam logic [3:0] STAT = 4'hA;  // status nibble of every frame
  localparam int CAL = 56;             // nominal calibration ticks
  localparam int PAUSE = 100;          // pause, elastic while idle
  localparam logic [5:0] NIB = 6'h01, CRCE = 6'h02, CALE = 6'h04;
  localparam logic [5:0] OFL = 6'h08, PP = 6'h10, EDGE = 6'h20;
  sentrx_channel dut_u (
    .clk(clk), .reset_n(reset_n), .sent_in(sent_in),
    .rx_enable(rx_enable), .pause_en(pause_en),
    .data_nibbles(data_nibbles), .tick_div(tick_div),
    .status_clear(status_clear), .channel_status(channel_status),
    .msg_data(msg_data), .msg_valid(msg_valid), .msg_ready(msg_ready)
  );
  sentrx_sensor sensor_u (.clk(clk), .sent_in(sent_in));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("compared %0d, mismatched %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // crc over data nibbles, msb first
  function automatic logic [3:0] crc_of(input int nib[$]);
    logic [3:0] c;
    c = sentrx_pkg::CRC_SEED;
    foreach (nib[i]) begin
      for (int b = 3; b >= 0; b--) begin
        c = {c[2:0], 1'b0} ^
            ((c[3] ^ nib[i][b]) ? sentrx_pkg::CRC_POLY : 4'h0);
      end
    end
    return c;
  endfunction
  // cal (skipped if 0), status, nibbles, crc xor cx, pause
  task automatic frame(input int cal, input int nib[$],
                       input logic [3:0] cx, input bit good);
    logic [sentrx_pkg::MSG_W-1:0] m;
    m = {STAT, 24'h0};
    if (cal > 0) sensor_u.pulse(cal);
    sensor_u.pulse(12 + STAT);
    foreach (nib[i]) begin
      sensor_u.pulse(12 + nib[i]);
      m[23:0] = {m[19:0], nib[i][3:0]};
    end
    sensor_u.pulse(12 + (crc_of(nib) ^ cx));
    sensor_u.pulse(PAUSE);
    if (good) exp_q.push_back(m);
  endtask
  // clear every flag for one cycle
  task automatic clr();
    status_clear = 6'h3F;
    @(negedge clk);
    status_clear = 6'h00;
  endtask
  // pop all queued messages, comparing them when chk is set
  task automatic drain(input bit chk);
    for (int n = 0; n < 12 && msg_valid === 1'b1; n++) begin
      if (chk) check(msg_data, exp_q.pop_front());
      msg_ready = 1'b1;
      @(negedge clk);
      msg_ready = 1'b0;
      repeat (2) @(negedge clk);
    end
    if (chk) check(exp_q.size(), 0);
    check(msg_valid, 1'b0);
    exp_q.delete();
  endtask
  // hang guard, far above the few thousand cycles the tests need
  initial begin
    repeat (40000) @(posedge clk);
    num_errors++;
    final_report();
  end
  initial begin
    reset_n = 1'b0;
    rx_enable = 1'b0;
    pause_en = 1'b1;
    data_nibbles = 3'h3;
    tick_div = 8'h01;
    status_clear = 6'h00;
    msg_ready = 1'b0;
    repeat (8) @(negedge clk);
    reset_n = 1'b1;
    // receive off: a broken frame is ignored
    frame(CAL, '{1, 20, 3}, 4'h3, 1'b0);
    check(channel_status, 6'h00);
    check(msg_valid, 1'b0);
    rx_enable = 1'b1;
    $display("test receive-off done");
    // clean traffic with boundary nibbles
    frame(CAL, '{0, 15, 9}, 4'h0, 1'b1);
    frame(CAL, '{7, 3, 12}, 4'h0, 1'b1);
    frame(CAL, '{15, 0, 5}, 4'h0, 1'b1);
    check(channel_status, 6'h00);
    drain(1'b1);
    $display("test clean done");
    // nibble error, then crc error: two edge errors each
    for (int k = 0; k < 2; k++) begin
      q = '{1, 2, 3};
      if (k == 0) q[1] = -5;
      clr();
      frame(CAL, q, k[3:0], 1'b0);
      check(channel_status, k ? CRCE : NIB);
      sensor_u.pulse(CAL);
      check(channel_status, (k ? CRCE : NIB) | EDGE);
      clr();
      frame(0, '{1, 2, 3}, 4'h0, 1'b0);
      check(channel_status, EDGE);
      clr();
      frame(CAL, '{4, 4, 4}, 4'h0, 1'b0);
      check(channel_status, 6'h00);
      drain(1'b0);
    end
    $display("test nibble and crc errors done");
    // calibration too long: edge errors at the next pause and at the good one after it
    q = '{2, 2, 2};
    frame(CAL, q, 4'h0, 1'b0);
    frame(80, q, 4'h0, 1'b0);
    frame(CAL, q, 4'h0, 1'b0);
    check(channel_status, CALE | EDGE);
    drain(1'b0);
    clr();
    // too few edges: pause lands in a data slot
    frame(CAL, '{1}, 4'h0, 1'b0);
    frame(CAL, '{1, 2, 3}, 4'h0, 1'b0);
    check(channel_status & (NIB | EDGE), NIB | EDGE);
    drain(1'b0);
    clr();
    // too many edges: late pause plus pause diagnostic; the slot the
    // receiver reads as crc matches, so surplus nibbles reach the pause
    q = '{1, 2, 3};
    q.push_back(crc_of(q));
    q.push_back(5);
    frame(CAL, q, 4'h0, 1'b0);
    frame(CAL, '{1, 2, 3}, 4'h0, 1'b0);
    check(channel_status & (NIB | PP | EDGE), NIB | PP | EDGE);
    drain(1'b0);
    $display("test length errors done");
    // fill the buffer past its depth while the consumer stalls
    clr();
    q = '{6, 7, 8};
    repeat (sentrx_pkg::FIFO_DEPTH + 1) frame(CAL, q, 4'h0, 1'b1);
    void'(exp_q.pop_back());
    check(channel_status & ~EDGE, OFL);
    drain(1'b1);
    check(channel_status & OFL, OFL);
    clr();
    check(channel_status, 6'h00);
    $display("test overflow done");
    final_report();
  end
endmodule
